/* common/thermo_regs.svh */
`ifndef THERMO_REGS_SVH
`define THERMO_REGS_SVH

// Register pointers on the device's register access port.
`define TMC_PTR_SENSOR_CFG 8'h05
`define TMC_PTR_DEVICE_CFG 8'h06

// Reset values.
`define TMC_SENSOR_CFG_RST 8'h00
`define TMC_DEVICE_CFG_RST 8'h00

// Sensor configuration fields.
`define TMC_SENSOR_CFG_MASK 8'h77
`define TMC_FILT_LSB 0
`define TMC_FILT_MSB 2
`define TMC_TYPE_LSB 4
`define TMC_TYPE_MSB 6

// Device configuration fields.
`define TMC_CJ_RES_BIT 7
`define TMC_ADC_RES_LSB 5
`define TMC_ADC_RES_MSB 6
`define TMC_BURST_LSB 2
`define TMC_BURST_MSB 4
`define TMC_MODE_LSB 0
`define TMC_MODE_MSB 1

// Number of alert comparators.
`define TMC_ALERT_COUNT 4

`endif

/* common/thermo_pkg.sv */
package thermo_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SHUTDOWN = 2'b01,
    MODE_BURST = 2'b10,
    MODE_KEEP = 2'b11
  } power_mode_t;

  typedef enum logic [2:0] {
    TC_K = 3'b000,
    TC_J = 3'b001,
    TC_T = 3'b010,
    TC_N = 3'b011,
    TC_S = 3'b100,
    TC_E = 3'b101,
    TC_B = 3'b110,
    TC_R = 3'b111
  } tc_type_t;

  typedef enum logic [1:0] {
    ADC_18BIT = 2'b00,
    ADC_16BIT = 2'b01,
    ADC_14BIT = 2'b10,
    ADC_12BIT = 2'b11
  } adc_res_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } seq_state_t;

endpackage

/* verilog/ema_filter.sv */
`timescale 1ns/1ps
module ema_filter #(
  parameter int W = 16
) (
  input wire logic clk_in, // Clock.
  input wire logic sys_rst_in, // Asynchronous reset, active high.
  input wire logic clear_in, // Filter state reset pulse.
  input wire logic [2:0] coeff_in, // Filter coefficient n.
  input wire logic x_valid_in, // New unfiltered sample.
  input wire logic signed [W-1:0] x_in, // Unfiltered sample.
  output logic y_valid_out, // Filtered result pulse.
  output logic signed [W-1:0] y_out // Filtered result.
);

  logic primed_reg;

  // Computes (2x + (2^n - 1) y1) / (2^n + 1), which equals k x + (1 - k) y1.
  function automatic logic signed [W-1:0] filt_step(input logic signed [W-1:0] x,
                                                    input logic signed [W-1:0] y1,
                                                    input logic [2:0] n);
    logic [W+9:0] pw;
    logic signed [W+9:0] xe;
    logic signed [W+9:0] ye;
    logic signed [W+9:0] den;
    logic signed [W+9:0] num;
    logic signed [W+9:0] q;
    pw = {{(W+9){1'b0}}, 1'b1} << n;
    xe = {{10{x[W-1]}}, x};
    ye = {{10{y1[W-1]}}, y1};
    den = $signed(pw + {{(W+9){1'b0}}, 1'b1});
    num = (xe <<< 1) + ye * $signed(pw - {{(W+9){1'b0}}, 1'b1});
    q = num / den;
    return q[W-1:0];
  endfunction

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      primed_reg <= 1'b0;
    end else if (x_valid_in) begin
      primed_reg <= 1'b1;
    end else if (clear_in) begin
      primed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      y_out <= '0;
      y_valid_out <= 1'b0;
    end else begin
      y_valid_out <= x_valid_in;
      if (x_valid_in) begin
        if (clear_in || !primed_reg) begin
          y_out <= x_in;
        end else begin
          y_out <= filt_step(x_in, y_out, coeff_in);
        end
      end
    end
  end

endmodule // ema_filter

/* verilog/alert_compare.sv */
`timescale 1ns/1ps
`include "thermo_regs.svh"
module alert_compare #(
  parameter int W = 16,
  parameter int N = `TMC_ALERT_COUNT
) (
  input wire logic clk_in, // Clock.
  input wire logic sys_rst_in, // Asynchronous reset, active high.
  input wire logic t_valid_in, // New temperature to compare.
  input wire logic signed [W-1:0] t_in, // Temperature under test.
  input wire logic [N*W-1:0] limit_in, // Packed signed alert limits.
  output logic [N-1:0] alert_out // One bit per limit, high above limit.
);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alert_out <= '0;
    end else if (t_valid_in) begin
      for (int i = 0; i < N; i++) begin
        alert_out[i] <= t_in > $signed(limit_in[i*W +: W]);
      end
    end
  end

endmodule // alert_compare

/* verilog/thermo_measure_control.sv */
`timescale 1ns/1ps
`include "thermo_regs.svh"
module thermo_measure_control #(
  parameter int W = 16
) (
  input wire logic clk_in, // Clock, 200 MHz.
  input wire logic sys_rst_in, // Asynchronous reset, active high.
  input wire logic reg_wr_in, // Register write strobe.
  input wire logic reg_rd_in, // Register read strobe.
  input wire logic [7:0] reg_ptr_in, // Register pointer.
  input wire logic [7:0] reg_wdata_in, // Register write data.
  output logic [7:0] reg_rdata_out, // Register read data.
  output logic reg_rvalid_out, // Read data valid pulse.
  output logic conv_start_out, // Conversion start pulse.
  output logic conv_busy_out, // Conversion in progress.
  output logic [2:0] conv_tc_type_out, // Thermocouple type for this conversion.
  output logic [1:0] conv_adc_res_out, // ADC resolution for this conversion.
  output logic conv_cj_res_out, // Cold-junction resolution for this conversion.
  input wire logic sample_valid_in, // Converter result strobe.
  input wire logic signed [W-1:0] sample_in, // Unfiltered hot-junction sample.
  output logic temp_valid_out, // Filtered temperature pulse.
  output logic signed [W-1:0] temp_out, // Filtered temperature.
  input wire logic [`TMC_ALERT_COUNT*W-1:0] alert_limit_in, // Packed alert limits.
  output logic [`TMC_ALERT_COUNT-1:0] alert_out, // Alert conditions.
  output logic shutdown_out, // Idle at idle_supply_current.
  output logic burst_done_out // Burst finished pulse.
);

  logic [7:0] sensor_cfg_reg;
  logic [7:0] device_cfg;
  logic cj_res_reg;
  logic [1:0] adc_res_reg;
  logic [2:0] burst_code_reg;
  thermo_pkg::power_mode_t mode_reg;
  logic [7:0] burst_left_reg;
  thermo_pkg::seq_state_t state_reg;
  thermo_pkg::power_mode_t mode;
  thermo_pkg::power_mode_t wr_mode;
  logic wr_sensor;
  logic wr_device;
  logic sample_take;
  logic burst_last;
  logic run_req;

  // Number of burst samples for a sample-count code.
  function automatic logic [7:0] burst_len(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  assign wr_sensor = reg_wr_in && (reg_ptr_in == `TMC_PTR_SENSOR_CFG);
  assign wr_device = reg_wr_in && (reg_ptr_in == `TMC_PTR_DEVICE_CFG);
  assign wr_mode = thermo_pkg::power_mode_t'(reg_wdata_in[`TMC_MODE_MSB:`TMC_MODE_LSB]);
  assign mode = mode_reg;
  assign device_cfg = {cj_res_reg, adc_res_reg, burst_code_reg, mode_reg};
  assign sample_take = (state_reg == thermo_pkg::ST_WAIT) && sample_valid_in &&
                       (mode != thermo_pkg::MODE_SHUTDOWN);
  assign burst_last = sample_take && (mode == thermo_pkg::MODE_BURST) &&
                      (burst_left_reg == 8'h01);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sensor_cfg_reg <= `TMC_SENSOR_CFG_RST;
    end else if (wr_sensor) begin
      sensor_cfg_reg <= reg_wdata_in & `TMC_SENSOR_CFG_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cj_res_reg <= 1'(`TMC_DEVICE_CFG_RST >> `TMC_CJ_RES_BIT);
    end else if (wr_device) begin
      cj_res_reg <= reg_wdata_in[`TMC_CJ_RES_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      adc_res_reg <= 2'(`TMC_DEVICE_CFG_RST >> `TMC_ADC_RES_LSB);
    end else if (wr_device) begin
      adc_res_reg <= reg_wdata_in[`TMC_ADC_RES_MSB:`TMC_ADC_RES_LSB];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_code_reg <= 3'(`TMC_DEVICE_CFG_RST >> `TMC_BURST_LSB);
    end else if (wr_device) begin
      burst_code_reg <= reg_wdata_in[`TMC_BURST_MSB:`TMC_BURST_LSB];
    end
  end

  // A host mode write (any mode but MODE_KEEP) outranks the automatic return to shutdown.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_reg <= thermo_pkg::power_mode_t'(2'(`TMC_DEVICE_CFG_RST));
    end else if (wr_device && (wr_mode != thermo_pkg::MODE_KEEP)) begin
      mode_reg <= wr_mode;
    end else if (burst_last) begin
      mode_reg <= thermo_pkg::MODE_SHUTDOWN;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_left_reg <= 8'h00;
    end else if (wr_device && (wr_mode == thermo_pkg::MODE_BURST)) begin
      burst_left_reg <= burst_len(reg_wdata_in[`TMC_BURST_MSB:`TMC_BURST_LSB]);
    end else if (sample_take && (mode == thermo_pkg::MODE_BURST)) begin
      burst_left_reg <= burst_left_reg - 8'h01;
    end
  end

  // Read port; unmapped pointers return zero.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        case (reg_ptr_in)
          `TMC_PTR_SENSOR_CFG: reg_rdata_out <= sensor_cfg_reg;
          `TMC_PTR_DEVICE_CFG: reg_rdata_out <= device_cfg;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  assign run_req = (mode == thermo_pkg::MODE_NORMAL) ||
                   ((mode == thermo_pkg::MODE_BURST) && (burst_left_reg != 8'h00));

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= thermo_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        thermo_pkg::ST_IDLE: begin
          if (run_req) begin
            state_reg <= thermo_pkg::ST_START;
          end
        end
        thermo_pkg::ST_START: begin
          state_reg <= thermo_pkg::ST_WAIT;
        end
        thermo_pkg::ST_WAIT: begin
          if (sample_valid_in || mode == thermo_pkg::MODE_SHUTDOWN) begin
            state_reg <= thermo_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= thermo_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign conv_start_out = (state_reg == thermo_pkg::ST_START);
  assign conv_busy_out = (state_reg != thermo_pkg::ST_IDLE);
  assign shutdown_out = (state_reg == thermo_pkg::ST_IDLE) &&
                        (mode == thermo_pkg::MODE_SHUTDOWN);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conv_tc_type_out <= thermo_pkg::TC_K;
      conv_adc_res_out <= thermo_pkg::ADC_18BIT;
      conv_cj_res_out <= 1'b0;
    end else if (state_reg == thermo_pkg::ST_IDLE && run_req) begin
      conv_tc_type_out <= sensor_cfg_reg[`TMC_TYPE_MSB:`TMC_TYPE_LSB];
      conv_adc_res_out <= adc_res_reg;
      conv_cj_res_out <= cj_res_reg;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_done_out <= 1'b0;
    end else begin
      burst_done_out <= burst_last;
    end
  end

  ema_filter #(
    .W(W)
  ) u_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(wr_sensor),
    .coeff_in(sensor_cfg_reg[`TMC_FILT_MSB:`TMC_FILT_LSB]),
    .x_valid_in(sample_take),
    .x_in(sample_in),
    .y_valid_out(temp_valid_out),
    .y_out(temp_out)
  );

  alert_compare #(
    .W(W),
    .N(`TMC_ALERT_COUNT)
  ) u_alert (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .t_valid_in(temp_valid_out),
    .t_in(temp_out),
    .limit_in(alert_limit_in),
    .alert_out(alert_out)
  );

endmodule // thermo_measure_control

/* dv/conv_partner.sv */
`timescale 1ns/1ps
module conv_partner (
  input wire logic clk_in, // Clock.
  input wire logic start_in, // Conversion start pulse.
  input wire logic busy_in, // Conversion in progress.
  output logic valid_out, // Result strobe.
  output logic signed [15:0] data_out // Result value.
);
  initial begin
    valid_out = 1'b0;
    data_out = 16'h0000;
  end
  // Answers a start after 1 to 4 cycles if busy is still high; the data lines churn when idle.
  always begin
    @(negedge clk_in);
    valid_out = 1'b0;
    data_out = 16'($urandom);
    if (start_in) begin
      repeat ($urandom_range(4, 1)) begin
        @(negedge clk_in);
        data_out = 16'($urandom);
      end
      if (busy_in) begin
        valid_out = 1'b1;
        data_out = 16'($urandom);
      end
    end
  end
endmodule // conv_partner

/* dv/thermo_measure_control_assertions.sv */
`timescale 1ns/1ps
`include "thermo_regs.svh"
module thermo_measure_control_checker #(
  parameter int W = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_ptr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic conv_start_out,
  input wire logic conv_busy_out,
  input wire logic [2:0] conv_tc_type_out,
  input wire logic [1:0] conv_adc_res_out,
  input wire logic conv_cj_res_out,
  input wire logic sample_valid_in,
  input wire logic temp_valid_out,
  input wire logic signed [W-1:0] temp_out,
  input wire logic [`TMC_ALERT_COUNT*W-1:0] alert_limit_in,
  input wire logic [`TMC_ALERT_COUNT-1:0] alert_out,
  input wire logic shutdown_out,
  input wire logic burst_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  function automatic logic [3:0] over(input logic signed [W-1:0] t, input logic [4*W-1:0] l);
    for (int i = 0; i < 4; i++) over[i] = t > $signed(l[W*i +: W]);
  endfunction
  logic mode_wr;
  logic shut_wr;
  assign mode_wr = reg_wr_in && reg_ptr_in == `TMC_PTR_DEVICE_CFG &&
                   reg_wdata_in[1:0] != 2'b11;
  assign shut_wr = mode_wr && reg_wdata_in[1:0] == 2'b01;
  // A shutdown write in the two cycles before aborts the conversion and drops the sample.
  sequence s_accept;
    sample_valid_in && conv_busy_out && !conv_start_out && !$past(shut_wr) &&
      !$past(shut_wr, 2);
  endsequence
  // A host mode write may start a new conversion two cycles later.
  sequence s_quiet;
    (!conv_start_out || $past(mode_wr, 2)) [*4];
  endsequence
  AST_RD_ANSWER: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  AST_RSVD_ZERO: assert property (reg_rvalid_out && $past(reg_ptr_in) == `TMC_PTR_SENSOR_CFG
    |-> reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0) else $error("reserved bit set");
  AST_SHDN_QUIET: assert property (shutdown_out |=> !conv_busy_out)
    else $error("activity in shutdown");
  AST_ACCEPT_TEMP: assert property (s_accept |=> temp_valid_out)
    else $error("sample gave no result");
  AST_TEMP_CAUSE: assert property (temp_valid_out |-> $past(sample_valid_in) &&
    $past(conv_busy_out)) else $error("result without sample");
  AST_CFG_HOLD: assert property (conv_busy_out && !conv_start_out |-> $stable(conv_adc_res_out)
    && $stable(conv_cj_res_out) && $stable(conv_tc_type_out)) else $error("settings moved");
  AST_ALERT_CMP: assert property (temp_valid_out |=>
    alert_out == over($past(temp_out), $past(alert_limit_in))) else $error("alert wrong");
  AST_BURST_END: assert property (burst_done_out && !$past(mode_wr) |->
    (shutdown_out && temp_valid_out) ##0 s_quiet) else $error("burst end wrong");
  AST_START_BUSY: assert property (conv_start_out |-> conv_busy_out ##1 !conv_start_out)
    else $error("start pulse wrong");
endmodule // thermo_measure_control_checker
bind thermo_measure_control thermo_measure_control_checker #(.W(W)) checker_i (.clk_in,
  .sys_rst_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_ptr_in, .reg_rdata_out,
  .reg_rvalid_out, .conv_start_out,
  .conv_busy_out, .conv_tc_type_out, .conv_adc_res_out, .conv_cj_res_out, .sample_valid_in,
  .temp_valid_out, .temp_out, .alert_limit_in, .alert_out, .shutdown_out, .burst_done_out);

/* dv/thermo_measure_control_tb_top.sv */
`timescale 1ns/1ps
`include "thermo_regs.svh"
module thermo_measure_control_tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_ptr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic conv_start_out;
  logic conv_busy_out;
  logic [2:0] conv_tc_type_out;
  logic [1:0] conv_adc_res_out;
  logic conv_cj_res_out;
  logic sample_valid_in;
  logic signed [15:0] sample_in;
  logic temp_valid_out;
  logic signed [15:0] temp_out;
  logic [63:0] alert_limit_in = 64'h0000_0000_0000_0000;
  logic [3:0] alert_out;
  logic shutdown_out;
  logic burst_done_out;
  logic [7:0] d;
  int n_fail = 0;
  int n_tests = 0;
  int n = 0;
  int fresh = 1;
  int y1 = 0;
  int ey = 0;
  int c;
  int md = 0;
  int left = 0;
  bit acc;
  logic [5:0] cfg = 6'h00;
  logic [5:0] cfg_now = 6'h00;
  logic [5:0] cfg_old = 6'h00;
  logic [7:0] conv_cfg;
  assign conv_cfg = {2'b00, conv_tc_type_out, conv_adc_res_out, conv_cj_res_out};
  always #2.5 clk_in = ~clk_in;
  thermo_measure_control thermo_measure_control_i (.clk_in, .sys_rst_in, .reg_wr_in,
    .reg_rd_in, .reg_ptr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .conv_start_out,
    .conv_busy_out, .conv_tc_type_out, .conv_adc_res_out, .conv_cj_res_out, .sample_valid_in,
    .sample_in, .temp_valid_out, .temp_out, .alert_limit_in, .alert_out, .shutdown_out,
    .burst_done_out);
  conv_partner conv_partner_i (.clk_in, .start_in(conv_start_out), .busy_in(conv_busy_out),
    .valid_out(sample_valid_in), .data_out(sample_in));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_ptr_in = p;
    reg_wdata_in = v;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    @(negedge clk_in);
    reg_rd_in = 1'b1;
    reg_ptr_in = p;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chk8({7'h00, reg_rvalid_out}, 8'h01);
    chk8(reg_rdata_out, e);
  endtask
  task automatic wait_temp;
    int k;
    for (k = 0; k < 100; k++) begin
      @(negedge clk_in);
      if (temp_valid_out) break;
    end
    if (k == 100) n_fail++;
  endtask
  task automatic quiet;
    repeat (20) begin
      @(negedge clk_in);
      chk8({6'h00, shutdown_out, conv_busy_out}, 8'h02);
    end
  endtask
  task automatic complete_run;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reference filter, updated on the same edges that the design uses.
  // Settings seen at a start are those in force one edge before the start pulse.
  always @(posedge clk_in) begin
    cfg_old = cfg_now;
    cfg_now = cfg;
    if (temp_valid_out) chk16(temp_out, ey[15:0]);
    if (conv_start_out) chk8(conv_cfg, {2'b00, cfg_old});
    acc = sample_valid_in && conv_busy_out && !conv_start_out && md != 1;
    if (reg_wr_in && reg_ptr_in == `TMC_PTR_SENSOR_CFG) begin
      n = reg_wdata_in[2:0];
      fresh = 1;
      cfg[5:3] = reg_wdata_in[6:4];
    end
    if (acc) begin
      ey = fresh ? sample_in : (2 * sample_in + ((1 << n) - 1) * y1) / ((1 << n) + 1);
      y1 = ey;
      fresh = 0;
      if (md == 2) begin
        left--;
        if (left == 0) md = 1;
      end
    end
    if (reg_wr_in && reg_ptr_in == `TMC_PTR_DEVICE_CFG) begin
      cfg[2:0] = {reg_wdata_in[6:5], reg_wdata_in[7]};
      if (reg_wdata_in[1:0] != 2'b11) md = reg_wdata_in[1:0];
      if (reg_wdata_in[1:0] == 2'b10) left = 1 << reg_wdata_in[4:2];
    end
  end
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
  initial begin
    void'($urandom(8));
    alert_limit_in = {$urandom, $urandom};
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd(`TMC_PTR_SENSOR_CFG, 8'h00);
    rd(`TMC_PTR_DEVICE_CFG, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[2:0], 1'b1, i[2:0]};
      wr(`TMC_PTR_SENSOR_CFG, d);
      rd(`TMC_PTR_SENSOR_CFG, d & `TMC_SENSOR_CFG_MASK);
      repeat (4) wait_temp;
    end
    wait_temp;
    wr(`TMC_PTR_DEVICE_CFG, 8'h01);
    repeat (2) @(negedge clk_in);
    quiet;
    for (int b = 0; b < 8; b++) begin
      d = {3'($urandom), b[2:0], 2'b10};
      wr(`TMC_PTR_DEVICE_CFG, d);
      c = 0;
      for (int k = 0; k < 3000 && !burst_done_out; k++) begin
        @(negedge clk_in);
        if (temp_valid_out) c++;
      end
      chk16(c[15:0], 16'(1 << b));
      rd(`TMC_PTR_DEVICE_CFG, {d[7:2], 2'b01});
      quiet;
    end
    wr(`TMC_PTR_DEVICE_CFG, 8'h03);
    rd(`TMC_PTR_DEVICE_CFG, 8'h01);
    wr(`TMC_PTR_DEVICE_CFG, 8'h00);
    repeat (3) wait_temp;
    complete_run;
  end
endmodule // thermo_measure_control_tb_top
